// file: halt_emulation_pkg.sv
// Constants and types for the halt, emulation and pin control block
`default_nettype none

package halt_emulation_pkg;

  // Enhancement control register, I/O address low byte
  localparam logic [7:0] ENH_ADDR = 8'hD9;
  localparam logic [7:0] ENH_RESET = 8'h00;
  localparam logic [7:0] ENH_WR_MASK = 8'h3F;
  localparam int ENH_FORCE_HALT_BIT = 5;
  localparam int ENH_TX_TRISTATE_BIT = 4;
  localparam int ENH_CLK_DIV_BIT = 3;

  // Timing
  localparam int HALT_RECOVERY_CYCLES = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_STRETCH_NS = 320;
  localparam int RESET_STRETCH_CYCLES = (RESET_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 6;

  // Emulation mode straps
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ADAPTER = 2'h1,
    MODE_PROBE = 2'h2,
    MODE_TEST = 2'h3
  } emuMode_t;

  // One field per pin; used for both levels and output enables
  typedef struct packed {
    logic sysClk;
    logic opFetch;
    logic memReq;
    logic ioReq;
    logic rdStrobe;
    logic wrStrobe;
    logic refresh;
    logic haltStat;
    logic status;
    logic eClk;
    logic busGrant;
    logic waitPin;
    logic [19:0] addr;
    logic [7:0] data;
    logic async_tx_ch0;
    logic request_to_send_ch0;
    logic async_tx_ch1;
    logic interrupt_request_0;
    logic serial_tx_a_pin;
    logic rom_chip_select;
    logic ram_chip_select;
    logic memWr;
    logic io_chip_select;
  } pins_t;

  // Pin function selects from the pin mux register
  typedef struct packed {
    logic memStrobeSel;
    logic ioCsSel;
  } pinSel_t;

endpackage

`default_nettype wire

// file: halt_emulation_pin_control.sv
// Halt, sleep and emulation pin control with the enhancement control register
// How it works
// - Bit 5 set skips the 16-cycle halt recovery and leaves pins under normal control.
// - Bit 5 clears to zero on every reset.
// - Bit 4 floats serial_tx_a_pin while halt status is asserted; off after reset.
// - Bit 5 set prevents serial_tx_a_pin floating during halt, whatever bit 4 says.
// - Bit 3 set halves the serial controller clock enable; clear gives full rate.
// - Register read and written at I/O address D9 hex, upper address byte ignored.
// - Adapter mode turns bus outputs into inputs, drives wait, floats async_tx_ch0, request_to_send_ch0 and async_tx_ch1.
// - Probe mode floats every output.
// - Normal mode stretches the reset pin through a one-shot; adapter mode bypasses it.
// - External reset reinitialises configuration, serial controller and UART emulation.
// - Crystal oscillator is disabled in modes 1 and 2.
// - In sleep or halt ROM and RAM chip selects drive high, memory strobes high when selected.
// - In sleep or halt read and write strobes float, I/O select when selected.
// - In power-down the address and data lines always float.
// - UART emulation logic is disabled while the core is powered down.
`timescale 1ns/100ps
`default_nettype none

module halt_emulation_pin_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // External reset pin and emulation mode straps
  input wire logic resetPinN,
  input wire logic [1:0] emuModePin,
  // Processor I/O access
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  output logic [7:0] ioRdData,
  output logic ioRdHit,
  // Core state and pin selects
  input wire logic coreHalt,
  input wire logic coreSleep,
  input wire halt_emulation_pkg::pinSel_t pinSel,
  // Core pin levels
  input wire halt_emulation_pkg::pins_t coreLevel,
  // Pin outputs and enables
  output halt_emulation_pkg::pins_t pinOut,
  output halt_emulation_pkg::pins_t pinOe,
  // System controls
  output logic intResetN,
  output logic oscEnable,
  output logic uartEmuEnable,
  output logic sccClkEn,
  output logic haltRecovering,
  output logic pinsHaltControl
);

  logic [1:0] modeMeta_q;
  logic [1:0] modeSync_q;
  logic resetMeta_q;
  logic resetSync_q;
  logic [halt_emulation_pkg::CNT_W-1:0] stretchCnt_q;
  logic intResetN_q;
  logic [7:0] enh_q;
  logic [7:0] ioRdData_q;
  logic ioRdHit_q;
  logic sccClkEn_q;
  logic haltPrev_q;
  logic [halt_emulation_pkg::CNT_W-1:0] recovCnt_q;
  halt_emulation_pkg::pins_t pinOut_q;
  halt_emulation_pkg::pins_t pinOe_q;
  halt_emulation_pkg::pins_t pinOut_d;
  halt_emulation_pkg::pins_t pinOe_d;
  halt_emulation_pkg::emuMode_t mode;
  logic forceHalt;
  logic powerDown;
  logic enhHit;

  assign mode = halt_emulation_pkg::emuMode_t'(modeSync_q);
  assign forceHalt = enh_q[halt_emulation_pkg::ENH_FORCE_HALT_BIT];
  assign powerDown = coreSleep | (coreHalt & ~forceHalt);
  assign enhHit = (ioAddr[7:0] == halt_emulation_pkg::ENH_ADDR);

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modeMeta_q <= 2'h0;
      modeSync_q <= 2'h0;
      resetMeta_q <= 1'b0;
      resetSync_q <= 1'b0;
    end else begin
      modeMeta_q <= emuModePin;
      modeSync_q <= modeMeta_q;
      resetMeta_q <= resetPinN;
      resetSync_q <= resetMeta_q;
    end
  end

  // Reset one-shot
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stretchCnt_q <= halt_emulation_pkg::CNT_W'(halt_emulation_pkg::RESET_STRETCH_CYCLES);
      intResetN_q <= 1'b0;
    end else if (mode == halt_emulation_pkg::MODE_ADAPTER) begin
      stretchCnt_q <= '0;
      intResetN_q <= resetSync_q;
    end else if (!resetSync_q) begin
      stretchCnt_q <= halt_emulation_pkg::CNT_W'(halt_emulation_pkg::RESET_STRETCH_CYCLES);
      intResetN_q <= 1'b0;
    end else if (stretchCnt_q != '0) begin
      stretchCnt_q <= stretchCnt_q - 1'b1;
      intResetN_q <= 1'b0;
    end else begin
      intResetN_q <= 1'b1;
    end
  end

  // Enhancement control register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enh_q <= halt_emulation_pkg::ENH_RESET;
    end else if (!intResetN_q) begin
      enh_q <= halt_emulation_pkg::ENH_RESET;
    end else if (ioWrEn && enhHit) begin
      enh_q <= ioWrData & halt_emulation_pkg::ENH_WR_MASK;
    end
  end

  // Register read port
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ioRdData_q <= 8'h00;
      ioRdHit_q <= 1'b0;
    end else begin
      ioRdHit_q <= ioRdEn & enhHit;
      ioRdData_q <= (ioRdEn && enhHit) ? (enh_q & halt_emulation_pkg::ENH_WR_MASK) : 8'h00;
    end
  end

  // Serial controller clock enable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sccClkEn_q <= 1'b1;
    end else if (!intResetN_q) begin
      sccClkEn_q <= 1'b1;
    end else if (enh_q[halt_emulation_pkg::ENH_CLK_DIV_BIT]) begin
      sccClkEn_q <= ~sccClkEn_q;
    end else begin
      sccClkEn_q <= 1'b1;
    end
  end

  // Halt recovery counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      haltPrev_q <= 1'b0;
      recovCnt_q <= '0;
    end else begin
      haltPrev_q <= coreHalt;
      if (forceHalt) begin
        recovCnt_q <= '0;
      end else if (haltPrev_q && !coreHalt) begin
        recovCnt_q <= halt_emulation_pkg::CNT_W'(halt_emulation_pkg::HALT_RECOVERY_CYCLES);
      end else if (recovCnt_q != '0) begin
        recovCnt_q <= recovCnt_q - 1'b1;
      end
    end
  end

  // Pin direction and level
  always_comb begin
    pinOut_d = coreLevel;
    pinOe_d = '1;
    pinOe_d.waitPin = 1'b0;
    pinOe_d.data = coreLevel.rdStrobe ? 8'h00 : 8'hFF;
    pinOe_d.interrupt_request_0 = 1'b0;
    pinOut_d.interrupt_request_0 = 1'b0;
    pinOe_d.memWr = pinSel.memStrobeSel;
    pinOe_d.io_chip_select = pinSel.ioCsSel;
    if (powerDown) begin
      pinOut_d.rom_chip_select = 1'b1;
      pinOut_d.ram_chip_select = 1'b1;
      if (pinSel.memStrobeSel) begin
        pinOut_d.memReq = 1'b1;
        pinOut_d.memWr = 1'b1;
      end
      pinOe_d.rdStrobe = 1'b0;
      pinOe_d.wrStrobe = 1'b0;
      if (pinSel.ioCsSel) begin
        pinOe_d.io_chip_select = 1'b0;
      end
      pinOe_d.addr = '0;
      pinOe_d.data = '0;
    end
    if (coreHalt && enh_q[halt_emulation_pkg::ENH_TX_TRISTATE_BIT] && !forceHalt) begin
      pinOe_d.serial_tx_a_pin = 1'b0;
    end
    unique case (mode)
      halt_emulation_pkg::MODE_NORMAL: begin
      end
      halt_emulation_pkg::MODE_ADAPTER: begin
        pinOe_d.sysClk = 1'b0;
        pinOe_d.opFetch = 1'b0;
        pinOe_d.memReq = 1'b0;
        pinOe_d.ioReq = 1'b0;
        pinOe_d.rdStrobe = 1'b0;
        pinOe_d.wrStrobe = 1'b0;
        pinOe_d.refresh = 1'b0;
        pinOe_d.haltStat = 1'b0;
        pinOe_d.status = 1'b0;
        pinOe_d.eClk = 1'b0;
        pinOe_d.busGrant = 1'b0;
        pinOe_d.addr = '0;
        pinOe_d.waitPin = 1'b1;
        pinOe_d.async_tx_ch0 = 1'b0;
        pinOe_d.request_to_send_ch0 = 1'b0;
        pinOe_d.async_tx_ch1 = 1'b0;
        pinOe_d.interrupt_request_0 = ~coreLevel.interrupt_request_0;
      end
      halt_emulation_pkg::MODE_PROBE: begin
        pinOe_d = '0;
      end
      halt_emulation_pkg::MODE_TEST: begin
        pinOe_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinOut_q <= '0;
      pinOe_q <= '0;
    end else begin
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
    end
  end

  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign ioRdData = ioRdData_q;
  assign ioRdHit = ioRdHit_q;
  assign intResetN = intResetN_q;
  assign sccClkEn = sccClkEn_q;
  assign haltRecovering = (recovCnt_q != '0);
  assign pinsHaltControl = powerDown;
  assign oscEnable = (mode != halt_emulation_pkg::MODE_ADAPTER) && (mode != halt_emulation_pkg::MODE_PROBE);
  assign uartEmuEnable = intResetN_q & ~powerDown;

  // Checks
  force_halt_skip_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    forceHalt |-> ##1 !haltRecovering)
    else $error("halt recovery ran with bit 5 set");

  recovery_length_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (haltPrev_q && !coreHalt && !forceHalt) |=>
      (recovCnt_q == halt_emulation_pkg::CNT_W'(halt_emulation_pkg::HALT_RECOVERY_CYCLES)))
    else $error("halt recovery count not loaded with 16");

  reset_clears_enh_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !intResetN_q |=> (enh_q == 8'h00))
    else $error("enhancement register not cleared by reset");

  tx_float_halt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (coreHalt && enh_q[halt_emulation_pkg::ENH_TX_TRISTATE_BIT] && !forceHalt) |=> !pinOe.serial_tx_a_pin)
    else $error("transmit pin driven during halt");

  tx_kept_force_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (forceHalt && mode == halt_emulation_pkg::MODE_NORMAL) |=> pinOe.serial_tx_a_pin)
    else $error("transmit pin floated with bit 5 set");

  clk_div_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (enh_q[halt_emulation_pkg::ENH_CLK_DIV_BIT] && $past(enh_q[halt_emulation_pkg::ENH_CLK_DIV_BIT]) &&
      intResetN_q && sccClkEn) |=> (enh_q[halt_emulation_pkg::ENH_CLK_DIV_BIT] -> !sccClkEn))
    else $error("divided serial clock enable not alternating");

  reg_readback_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ioRdEn && enhHit) |=> (ioRdHit && ioRdData == ($past(enh_q) & halt_emulation_pkg::ENH_WR_MASK)))
    else $error("register read returned wrong value");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    enh_q[7:6] == 2'h0)
    else $error("reserved enhancement bits set");

  probe_float_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mode == halt_emulation_pkg::MODE_PROBE) |=> (pinOe == '0))
    else $error("output driven in probe mode");

  adapter_dirs_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mode == halt_emulation_pkg::MODE_ADAPTER) |=> (pinOe.waitPin && !pinOe.sysClk && pinOe.addr == '0))
    else $error("adapter mode pin directions wrong");

  osc_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (modeSync_q == 2'h1 || modeSync_q == 2'h2) |-> !oscEnable)
    else $error("oscillator enabled in emulation mode");

  sleep_pins_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (powerDown && mode == halt_emulation_pkg::MODE_NORMAL) |=>
      (pinOut.rom_chip_select && pinOut.ram_chip_select && !pinOe.rdStrobe && !pinOe.wrStrobe && pinOe.data == '0))
    else $error("power-down pin state wrong");

  uart_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    powerDown |-> !uartEmuEnable)
    else $error("UART emulation enabled in power-down");

  stretch_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mode == halt_emulation_pkg::MODE_NORMAL && !resetSync_q) ##1
      (mode == halt_emulation_pkg::MODE_NORMAL && resetSync_q) |-> !intResetN[*8])
    else $error("internal reset not stretched");

endmodule

`default_nettype wire

// file: pin_far_model.sv
// Far side of the pins: external memory, peripherals or emulator adapter
`timescale 1ns/100ps
`default_nettype none

module pin_far_model (
  // Clock and mode
  input wire logic clk_sys,
  input wire logic adapterMode,
  // Device pin drive
  input wire halt_emulation_pkg::pins_t pinOut,
  input wire halt_emulation_pkg::pins_t pinOe,
  // Resolved wire levels
  output halt_emulation_pkg::pins_t wireLvl
);
  halt_emulation_pkg::pins_t lastQ = '0;
  halt_emulation_pkg::pins_t farOe;
  halt_emulation_pkg::pins_t farDrv;

  // Released wires show a changing pattern
  always_ff @(posedge clk_sys) begin
    lastQ <= wireLvl;
  end

  // Emulator drives memory request and address bit 18
  always_comb begin
    farOe = '0;
    farDrv = '0;
    if (adapterMode) begin
      farOe.memReq = 1'b1;
      farOe.addr[18] = 1'b1;
      farDrv.memReq = lastQ.memReq;
      farDrv.addr[18] = ~lastQ.addr[18];
    end
    wireLvl = (pinOe & pinOut) | (~pinOe & farOe & farDrv) | (~pinOe & ~farOe & ~lastQ);
  end
endmodule

`default_nettype wire

// file: halt_emulation_pin_control_tb.sv
// Self-checking bench for the halt, emulation and pin control block
`timescale 1ns/100ps
`default_nettype none

module halt_emulation_pin_control_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic resetPinN = 1'b1;
  logic ioWrEn = 1'b0;
  logic ioRdEn = 1'b0;
  logic coreHalt = 1'b0;
  logic coreSleep = 1'b0;
  logic [1:0] emuModePin = 2'h0;
  logic [15:0] ioAddr = 16'h0000;
  logic [7:0] ioWrData = 8'h00;
  logic [7:0] ioRdData;
  logic ioRdHit, intResetN, oscEnable, uartEmuEnable, sccClkEn, haltRecovering, pinsHaltControl;
  halt_emulation_pkg::pinSel_t pinSel = '1;
  halt_emulation_pkg::pins_t coreLevel = '0;
  halt_emulation_pkg::pins_t pinOut, pinOe, wireLvl;
  logic [31:0] seed = 32'h5271;
  logic [7:0] enh = 8'h00;
  logic [7:0] hv [3] = '{8'h00, 8'h10, 8'h30};
  int nErrors = 0;
  int checkCount = 0;
  int cnt;

  halt_emulation_pin_control halt_emulation_pin_control_i (.clk_sys(clk_sys), .rstn(rstn),
    .resetPinN(resetPinN), .emuModePin(emuModePin), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioRdData(ioRdData), .ioRdHit(ioRdHit), .coreHalt(coreHalt),
    .coreSleep(coreSleep), .pinSel(pinSel), .coreLevel(coreLevel), .pinOut(pinOut), .pinOe(pinOe),
    .intResetN(intResetN), .oscEnable(oscEnable), .uartEmuEnable(uartEmuEnable), .sccClkEn(sccClkEn),
    .haltRecovering(haltRecovering), .pinsHaltControl(pinsHaltControl));

  pin_far_model pin_far_model_i (.clk_sys(clk_sys), .adapterMode(emuModePin == 2'h1), .pinOut(pinOut),
    .pinOe(pinOe), .wireLvl(wireLvl));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic tallyAndFinish;
    $display("checks=%0d mismatches=%0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic waitRst;
    cnt = 0;
    while (intResetN !== 1'b1 && cnt < 200) begin
      cyc(1);
      cnt++;
    end
    if (cnt >= 200) begin
      chk(64'h0, 64'h1);
      tallyAndFinish;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1'b1;
    cyc(1);
    ioWrEn = 1'b0;
    if (a[7:0] == halt_emulation_pkg::ENH_ADDR) enh = d & halt_emulation_pkg::ENH_WR_MASK;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    ioAddr = a;
    ioRdEn = 1'b1;
    cyc(1);
    ioRdEn = 1'b0;
    chk(ioRdHit, h);
    chk(ioRdData, e);
    cyc(1);
  endtask

  // Low cycles of the internal reset after a reset pin pulse
  task automatic pinPulse(input int n);
    resetPinN = 1'b0;
    cyc(5);
    resetPinN = 1'b1;
    cnt = 0;
    repeat (n) begin
      cyc(1);
      cnt += (intResetN === 1'b0);
    end
  endtask

  initial begin
    cyc(10);
    rstn = 1'b1;
    waitRst;
    rd(16'h00D9, 8'h00, 1'b1);
    cnt = 0;
    repeat (8) begin cyc(1); cnt += (sccClkEn !== 1'b0); end
    chk(cnt, 8);
    wr(16'hA5D9, 8'hFF);
    rd(16'h12D9, 8'h3F, 1'b1);
    rd(16'h00D8, 8'h00, 1'b0);
    repeat (24) begin
      seed = xs(seed);
      wr({seed[31:24], seed[0] ? 8'hD9 : seed[15:8]}, seed[23:16]);
      rd({seed[7:0], 8'hD9}, enh, 1'b1);
    end
    wr(16'h00D9, 8'h08);
    cnt = 0;
    repeat (8) begin cyc(1); cnt += (sccClkEn !== 1'b0); end
    chk(cnt, 4);
    $display("register tests done");
    for (int k = 0; k < 3; k++) begin
      wr(16'h00D9, hv[k]);
      seed = xs(seed);
      coreLevel = {seed[16:0], seed};
      coreHalt = 1'b1;
      cyc(2);
      chk(pinOe.serial_tx_a_pin, k != 1);
      chk(pinsHaltControl, k != 2);
      chk(uartEmuEnable, k == 2);
      if (k < 2) begin
        chk({pinOut.rom_chip_select, pinOe.rom_chip_select, pinOut.ram_chip_select, wireLvl.rom_chip_select, pinOut.memReq, pinOut.memWr}, 6'h3F);
        chk({pinOe.rdStrobe, pinOe.wrStrobe, pinOe.io_chip_select, pinOe.addr, pinOe.data}, 0);
      end
      coreHalt = 1'b0;
      cnt = 0;
      repeat (20) begin cyc(1); cnt += (haltRecovering !== 1'b0); end
      chk(cnt, (k == 2) ? 0 : 16);
    end
    coreSleep = 1'b1;
    cyc(2);
    chk({pinOe.addr, pinOe.data, pinOut.rom_chip_select, uartEmuEnable}, 30'h2);
    pinSel = '0;
    coreLevel.memReq = 1'b0;
    coreLevel.memWr = 1'b0;
    cyc(2);
    chk({pinOut.memReq, pinOut.memWr, pinOut.ram_chip_select, pinOe.io_chip_select}, 4'h2);
    pinSel = '1;
    coreSleep = 1'b0;
    $display("halt and sleep tests done");
    emuModePin = 2'h2; // Mode 3 never driven
    cyc(5);
    chk({pinOe, oscEnable}, 0);
    emuModePin = 2'h1;
    coreLevel.interrupt_request_0 = 1'b0;
    cyc(5);
    chk({oscEnable, pinOe.sysClk, pinOe.addr, pinOe.waitPin, pinOe.async_tx_ch0, pinOe.request_to_send_ch0, pinOe.async_tx_ch1}, 5'h08);
    chk({pinOe.interrupt_request_0, pinOut.interrupt_request_0}, 2'h2);
    chk({pinOe.memReq, pinOe.opFetch, pinOe.busGrant, pinOe.eClk}, 4'h0);
    wr(16'h00D9, 8'h3F);
    pinPulse(40);
    chk(cnt >= 1 && cnt <= 4, 1);
    rd(16'h00D9, 8'h00, 1'b1);
    emuModePin = 2'h0;
    cyc(5);
    chk(oscEnable, 1);
    wr(16'h00D9, 8'h3F);
    pinPulse(50);
    chk(cnt >= 32 && cnt <= 36, 1);
    waitRst;
    rd(16'h00D9, 8'h00, 1'b1);
    $display("mode and reset tests done");
    tallyAndFinish;
  end
endmodule

`default_nettype wire
